// *** design/pam_pkg.sv ***
// Constants and types shared by the port A/B/C pin multiplexer.
// Assumes one 50 MHz core clock; configuration arrives as plain ports.
`default_nettype none

package pam_pkg;

  localparam int PAM_CFG_WIDTH    = 8;
  localparam int PAM_PA_WIDTH     = 2;
  localparam int PAM_PB_WIDTH     = 8;
  localparam int PAM_PC_WIDTH     = 3;
  localparam int PAM_STROBE_WIDTH = 4;

  // Bit positions within the configuration words.
  localparam int PAM_POL_COMMIT_BIT = 5;
  localparam int PAM_PA_ALT_BIT     = 7;
  localparam int PAM_EP_WORD_BIT    = 0;

  // Layout of the synchroniser vector: PA6, PA7, PB[7:0], PC[2:0].
  localparam int PAM_SYNC_PA6    = 0;
  localparam int PAM_SYNC_PA7    = 1;
  localparam int PAM_SYNC_PB_LSB = 2;
  localparam int PAM_SYNC_PC_LSB = 10;
  localparam int PAM_SYNC_WIDTH  = 13;

  // Output enables are active low: low means the pin is driven.
  localparam logic PAM_OE_N_DRIVE   = 1'b0;
  localparam logic PAM_OE_N_RELEASE = 1'b1;

  typedef enum logic [1:0] {
    PAM_MODE_PORTS    = 2'h0,
    PAM_MODE_RESERVED = 2'h1,
    PAM_MODE_WAVEFORM = 2'h2,
    PAM_MODE_FIFO     = 2'h3
  } pam_mode_type;

  typedef enum logic [1:0] {
    PAM_PA7_PORT = 2'h0,
    PAM_PA7_FLAG = 2'h1,
    PAM_PA7_CS   = 2'h3
  } pam_pa7_fn_type;

  typedef enum logic [1:0] {
    PAM_FLAG_EMPTY = 2'h0,
    PAM_FLAG_FULL  = 2'h1,
    PAM_FLAG_PROG  = 2'h3
  } pam_flag_sel_type;

endpackage

`default_nettype wire

// *** design/pam_sync.sv ***
// Two-flop synchroniser bank for the multiplexed pin inputs.
// Assumes the pins are asynchronous to clk_in.
`default_nettype none

module pam_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,     // Core clock.
  input  wire logic             reset_n_in, // Async reset, active low.
  input  wire logic [WIDTH-1:0] async_in,   // Raw pin levels.
  output logic      [WIDTH-1:0] sync_out    // Levels on clk_in.
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// *** design/pam_port_abc_mux.sv ***
// Pin multiplexer for port A bits 6-7, port B and port C bits 0-2.
// Assumes configuration and engine signals are on clk_in; pins are not.
// Overview of operation
// - PA6 is a port bit or packet-commit input, by the interface mode.
// - An asserted packet-commit input commits the current FIFO packet while chip select permits.
// - Polarity bit 5 sets the active level of packet commit.
// - PA7 is port bit, flag D or chip select by mode and alt bit 7.
// - As flag D, PA7 is driven with a selectable FIFO condition.
// - With chip select in use, strobes count only while it is low.
// - All port B pins switch between port bits and FIFO data low byte.
// - As FIFO data, port B pins work in both directions.
// - Each of PC0-PC2 follows its own port C alternate bit.
// - A PC pin in address function is a driven output of that bit.
// - In port function every pin drives, reads or floats as GPIO.
// - Port D is the upper data byte only in bus mode and word-wide.
`default_nettype none

module pam_port_abc_mux
  import pam_pkg::*;
(
  input  wire logic                    clk_in,                      // Clock.
  input  wire logic                    reset_n_in,                  // Reset.
  input  wire logic [1:0]              interface_mode_config_in,    // Mode.
  input  wire logic [pam_pkg::PAM_CFG_WIDTH-1:0]
                                       fifo_pin_polarity_config_in, // Pol.
  input  wire logic [pam_pkg::PAM_CFG_WIDTH-1:0]
                                       port_a_alt_config_in,        // PA alt.
  input  wire logic [pam_pkg::PAM_CFG_WIDTH-1:0]
                                       port_c_alt_config_in,        // PC alt.
  input  wire logic [pam_pkg::PAM_CFG_WIDTH-1:0]
                                       endpoint_fifo_config_in,     // EP cfg.
  input  wire logic [1:0]              flag_d_select_in,            // Flag.
  input  wire logic                    fifo_empty_in,               // Empty.
  input  wire logic                    fifo_full_in,                // Full.
  input  wire logic                    fifo_prog_level_in,          // Level.
  input  wire logic [pam_pkg::PAM_PA_WIDTH-1:0]
                                       port_a_data_in,              // PA6/7.
  input  wire logic [pam_pkg::PAM_PA_WIDTH-1:0]
                                       port_a_drive_in,             // PA dir.
  input  wire logic [pam_pkg::PAM_PB_WIDTH-1:0]
                                       port_b_data_in,              // PB out.
  input  wire logic [pam_pkg::PAM_PB_WIDTH-1:0]
                                       port_b_drive_in,             // PB dir.
  input  wire logic [pam_pkg::PAM_PC_WIDTH-1:0]
                                       port_c_data_in,              // PC out.
  input  wire logic [pam_pkg::PAM_PC_WIDTH-1:0]
                                       port_c_drive_in,             // PC dir.
  input  wire logic [pam_pkg::PAM_PB_WIDTH-1:0]
                                       fifo_data_bus_in,            // To pins.
  input  wire logic                    fifo_data_drive_in,          // Drive.
  input  wire logic [pam_pkg::PAM_PC_WIDTH-1:0]
                                       waveform_if_addr_in,         // Addr.
  input  wire logic [pam_pkg::PAM_STROBE_WIDTH-1:0]
                                       fifo_strobes_in,             // Strobes.
  input  wire logic                    port_a_bit6_in,              // Pin.
  output logic                         port_a_bit6_out,             // Pin.
  output logic                         port_a_bit6_oe_n_out,        // Pin OE.
  input  wire logic                    port_a_bit7_in,              // Pin.
  output logic                         port_a_bit7_out,             // Pin.
  output logic                         port_a_bit7_oe_n_out,        // Pin OE.
  input  wire logic [pam_pkg::PAM_PB_WIDTH-1:0]
                                       port_b_pin_in,               // Pins.
  output logic      [pam_pkg::PAM_PB_WIDTH-1:0]
                                       port_b_pin_out,              // Pins.
  output logic      [pam_pkg::PAM_PB_WIDTH-1:0]
                                       port_b_oe_n_out,             // Pin OE.
  input  wire logic [pam_pkg::PAM_PC_WIDTH-1:0]
                                       port_c_pin_in,               // Pins.
  output logic      [pam_pkg::PAM_PC_WIDTH-1:0]
                                       port_c_pin_out,              // Pins.
  output logic      [pam_pkg::PAM_PC_WIDTH-1:0]
                                       port_c_oe_n_out,             // Pin OE.
  output logic      [pam_pkg::PAM_PA_WIDTH-1:0]
                                       port_a_read_out,             // PA read.
  output logic      [pam_pkg::PAM_PB_WIDTH-1:0]
                                       port_b_read_out,             // PB read.
  output logic      [pam_pkg::PAM_PC_WIDTH-1:0]
                                       port_c_read_out,             // PC read.
  output logic      [pam_pkg::PAM_PB_WIDTH-1:0]
                                       fifo_data_bus_out,           // From pin.
  output logic                         packet_commit_out,           // Pulse.
  output logic                         slave_selected_out,          // CS ok.
  output logic      [pam_pkg::PAM_STROBE_WIDTH-1:0]
                                       gated_strobes_out,           // Gated.
  output logic                         port_d_upper_sel_out         // PD bus.
);

  import pam_pkg::*;

  function automatic logic is_bus_mode(input pam_mode_type mode);
    is_bus_mode = (mode == PAM_MODE_WAVEFORM) || (mode == PAM_MODE_FIFO);
  endfunction

  logic [PAM_SYNC_WIDTH-1:0] sync_w;

  pam_sync #(
    .WIDTH (PAM_SYNC_WIDTH)
  ) u_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({port_c_pin_in, port_b_pin_in, port_a_bit7_in,
                  port_a_bit6_in}),
    .sync_out   (sync_w)
  );

  // Configuration state.
  pam_mode_type                 mode_q,   mode_d;
  pam_pa7_fn_type               pa7_fn_q, pa7_fn_d;
  logic [PAM_PC_WIDTH-1:0]      pc_alt_q, pc_alt_d;
  logic                         pol_q,    pol_d;
  logic                         word_q,   word_d;

  // Registered config starts in port mode, so every pin is plain GPIO.
  always_comb begin
    mode_d   = pam_mode_type'(interface_mode_config_in);
    pc_alt_d = port_c_alt_config_in[PAM_PC_WIDTH-1:0];
    pol_d    = fifo_pin_polarity_config_in[PAM_POL_COMMIT_BIT];
    word_d   = endpoint_fifo_config_in[PAM_EP_WORD_BIT];
    pa7_fn_d = PAM_PA7_PORT;
    if (mode_d == PAM_MODE_FIFO) begin
      pa7_fn_d = port_a_alt_config_in[PAM_PA_ALT_BIT] ? PAM_PA7_CS
                                                      : PAM_PA7_FLAG;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_q   <= PAM_MODE_PORTS;
      pa7_fn_q <= PAM_PA7_PORT;
      pc_alt_q <= '0;
      pol_q    <= 1'b0;
      word_q   <= 1'b0;
    end else begin
      mode_q   <= mode_d;
      pa7_fn_q <= pa7_fn_d;
      pc_alt_q <= pc_alt_d;
      pol_q    <= pol_d;
      word_q   <= word_d;
    end
  end

  // Pin drive state.
  logic                    pa6_q,    pa6_d;
  logic                    pa6_oe_q, pa6_oe_d;
  logic                    pa7_q,    pa7_d;
  logic                    pa7_oe_q, pa7_oe_d;
  logic [PAM_PB_WIDTH-1:0] pb_q,     pb_d;
  logic [PAM_PB_WIDTH-1:0] pb_oe_q,  pb_oe_d;
  logic [PAM_PC_WIDTH-1:0] pc_q,     pc_d;
  logic [PAM_PC_WIDTH-1:0] pc_oe_q,  pc_oe_d;
  logic                    flag_val;
  logic                    sel_q;

  always_comb begin
    unique case (flag_d_select_in)
      PAM_FLAG_EMPTY: flag_val = fifo_empty_in;
      PAM_FLAG_FULL:  flag_val = fifo_full_in;
      PAM_FLAG_PROG:  flag_val = fifo_prog_level_in;
      default:        flag_val = 1'b0;
    endcase

    pa6_d    = port_a_data_in[0];
    pa6_oe_d = ~port_a_drive_in[0];
    if (mode_q == PAM_MODE_FIFO) begin
      pa6_oe_d = PAM_OE_N_RELEASE;
    end

    unique case (pa7_fn_q)
      PAM_PA7_PORT: begin
        pa7_d    = port_a_data_in[1];
        pa7_oe_d = ~port_a_drive_in[1];
      end
      PAM_PA7_FLAG: begin
        pa7_d    = flag_val;
        pa7_oe_d = PAM_OE_N_DRIVE;
      end
      PAM_PA7_CS: begin
        pa7_d    = 1'b0;
        pa7_oe_d = PAM_OE_N_RELEASE;
      end
      default: begin
        pa7_d    = 1'b0;
        pa7_oe_d = PAM_OE_N_RELEASE;
      end
    endcase

    // The engine's drive request is honoured only while chip select
    // permits, so a deselected device never fights another on the bus.
    if (is_bus_mode(mode_q)) begin
      pb_d    = fifo_data_bus_in;
      pb_oe_d = {PAM_PB_WIDTH{~(fifo_data_drive_in & sel_q)}};
    end else begin
      pb_d    = port_b_data_in;
      pb_oe_d = ~port_b_drive_in;
    end

    for (int i = 0; i < PAM_PC_WIDTH; i++) begin
      if (pc_alt_q[i]) begin
        pc_d[i]    = waveform_if_addr_in[i];
        pc_oe_d[i] = PAM_OE_N_DRIVE;
      end else begin
        pc_d[i]    = port_c_data_in[i];
        pc_oe_d[i] = ~port_c_drive_in[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pa6_q    <= 1'b0;
      pa6_oe_q <= PAM_OE_N_RELEASE;
      pa7_q    <= 1'b0;
      pa7_oe_q <= PAM_OE_N_RELEASE;
      pb_q     <= '0;
      pb_oe_q  <= {PAM_PB_WIDTH{PAM_OE_N_RELEASE}};
      pc_q     <= '0;
      pc_oe_q  <= {PAM_PC_WIDTH{PAM_OE_N_RELEASE}};
    end else begin
      pa6_q    <= pa6_d;
      pa6_oe_q <= pa6_oe_d;
      pa7_q    <= pa7_d;
      pa7_oe_q <= pa7_oe_d;
      pb_q     <= pb_d;
      pb_oe_q  <= pb_oe_d;
      pc_q     <= pc_d;
      pc_oe_q  <= pc_oe_d;
    end
  end

  // Slave FIFO control state.
  logic                        sel_d;
  logic                        act_q,    act_d;
  logic                        commit_q, commit_d;
  logic [PAM_STROBE_WIDTH-1:0] strb_q,   strb_d;
  logic                        pd_q,     pd_d;

  always_comb begin
    // Chip select is active low; without that function always selected.
    sel_d    = (pa7_fn_q != PAM_PA7_CS) |
               ~sync_w[PAM_SYNC_PA7];
    act_d    = (mode_q == PAM_MODE_FIFO) &&
               (sync_w[PAM_SYNC_PA6] == pol_q);
    // One pulse per selected assertion; a level held at the active polarity commits only once.
    commit_d = act_d & ~act_q & sel_q;
    strb_d   = fifo_strobes_in & {PAM_STROBE_WIDTH{sel_q}};
    pd_d     = is_bus_mode(mode_q) & word_q;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sel_q    <= 1'b1;
      act_q    <= 1'b0;
      commit_q <= 1'b0;
      strb_q   <= '0;
      pd_q     <= 1'b0;
    end else begin
      sel_q    <= sel_d;
      act_q    <= act_d;
      commit_q <= commit_d;
      strb_q   <= strb_d;
      pd_q     <= pd_d;
    end
  end

  assign port_a_bit6_out      = pa6_q;
  assign port_a_bit6_oe_n_out = pa6_oe_q;
  assign port_a_bit7_out      = pa7_q;
  assign port_a_bit7_oe_n_out = pa7_oe_q;
  assign port_b_pin_out       = pb_q;
  assign port_b_oe_n_out      = pb_oe_q;
  assign port_c_pin_out       = pc_q;
  assign port_c_oe_n_out      = pc_oe_q;
  assign port_a_read_out      = sync_w[PAM_SYNC_PA7:PAM_SYNC_PA6];
  assign port_b_read_out      =
    sync_w[PAM_SYNC_PB_LSB +: PAM_PB_WIDTH];
  assign port_c_read_out      =
    sync_w[PAM_SYNC_PC_LSB +: PAM_PC_WIDTH];
  assign fifo_data_bus_out    =
    sync_w[PAM_SYNC_PB_LSB +: PAM_PB_WIDTH];
  assign packet_commit_out    = commit_q;
  assign slave_selected_out   = sel_q;
  assign gated_strobes_out    = strb_q;
  assign port_d_upper_sel_out = pd_q;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  chk_pa6_released: assert property (
    (interface_mode_config_in == PAM_MODE_FIFO) [*2]
      |-> ##2 port_a_bit6_oe_n_out)
    else $error("PA6 driven while in packet-commit mode");

  chk_commit_edge: assert property (
    packet_commit_out |-> act_q && !$past(act_q) && $past(sel_q)
      ##1 !packet_commit_out)
    else $error("Packet commit pulse without a fresh selected edge");

  chk_commit_level: assert property (
    act_q |-> $past(sync_w[PAM_SYNC_PA6]) == $past(pol_q))
    else $error("Packet commit seen at the wrong polarity");

  chk_flag_drive: assert property (
    pa7_fn_q == PAM_PA7_FLAG |=> !port_a_bit7_oe_n_out &&
      port_a_bit7_out == $past(flag_val))
    else $error("Flag D not driven with the selected condition");

  chk_cs_gates: assert property (
    !sel_q |=> gated_strobes_out == '0 && !packet_commit_out)
    else $error("Strobe passed while chip select is inactive");

  chk_cs_input: assert property (
    pa7_fn_q == PAM_PA7_CS |=> port_a_bit7_oe_n_out)
    else $error("PA7 driven while used as chip select");

  chk_pb_gpio: assert property (
    !is_bus_mode(mode_q) |=> port_b_oe_n_out == ~$past(port_b_drive_in)
      && port_b_pin_out == $past(port_b_data_in))
    else $error("Port B not following GPIO in port mode");

  chk_pc_addr: assert property (
    pc_alt_q[0] |=> !port_c_oe_n_out[0] &&
      port_c_pin_out[0] == $past(waveform_if_addr_in[0]))
    else $error("PC0 not driving the waveform address");

  chk_pd_word: assert property (
    port_d_upper_sel_out |-> $past(word_q) && $past(is_bus_mode(mode_q)))
    else $error("Port D selected without word-wide bus mode");

  chk_pa6_gpio: assert property (
    mode_q != PAM_MODE_FIFO |=>
      port_a_bit6_oe_n_out == !$past(port_a_drive_in[0]))
    else $error("PA6 not following GPIO direction");

  cov_commit:   cover property (packet_commit_out);
  cov_deselect: cover property (pa7_fn_q == PAM_PA7_CS && !sel_q);
  cov_flag:     cover property (pa7_fn_q == PAM_PA7_FLAG ##1 port_a_bit7_out);
  cov_pb_drive: cover property (is_bus_mode(mode_q) && pb_oe_q == '0);

endmodule

`default_nettype wire

// *** bench/pam_fifo_master.sv ***
// Model of the external FIFO master on PA6, PA7 and port B.
// Assumes design pin outputs with active-low enables; resolves each wire.
`default_nettype none

module pam_fifo_master (
  input  wire logic       clk_in,      // Core clock.
  input  wire logic       commit_in,   // Command: assert packet commit.
  input  wire logic       pol_high_in, // Commit is active high.
  input  wire logic       select_in,   // Command: assert chip select.
  input  wire logic       drive_in,    // Command: drive port B.
  input  wire logic [7:0] data_in,     // Value driven on port B.
  input  wire logic       pa6_in,      // Design PA6 level.
  input  wire logic       pa6_oe_n_in, // Design PA6 enable.
  input  wire logic       pa7_in,      // Design PA7 level.
  input  wire logic       pa7_oe_n_in, // Design PA7 enable.
  input  wire logic [7:0] pb_in,       // Design port B levels.
  input  wire logic [7:0] pb_oe_n_in,  // Design port B enables.
  output logic            pa6_out,     // Resolved PA6 wire.
  output logic            pa7_out,     // Resolved PA7 wire.
  output logic      [7:0] pb_out       // Resolved port B wires.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_q;
  logic [7:0] ext;
  // Commit level follows the programmed polarity.
  assign pa6_out = pa6_oe_n_in ? (commit_in ~^ pol_high_in) : pa6_in;
  // Chip select is active low.
  assign pa7_out = pa7_oe_n_in ? ~select_in : pa7_in;
  // A bus nobody drives must not look as if it kept its value.
  assign ext = drive_in ? data_in : ~last_q;
  assign pb_out = (pb_in & ~pb_oe_n_in) | (ext & pb_oe_n_in);
  always @(posedge clk_in) last_q <= pb_out;
endmodule

`default_nettype wire

// *** bench/test_pam_port_abc_mux.sv ***
// Self-checking testbench for the port A/B/C pin multiplexer.
// Assumes the FIFO master model resolves PA6, PA7 and port B wires.
`default_nettype none

module test_pam_port_abc_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_in = 1'b0;
  logic       reset_n = 1'b0;
  logic [1:0] mode = 2'h0, flag_sel = 2'h0, pa_dat = 2'h0, pa_drv = 2'h0;
  logic [7:0] pol = 8'h20, pa_alt = 8'h00, pc_alt = 8'h00, ep_cfg = 8'h01;
  logic [2:0] cond = 3'h0, pc_dat = 3'h0, pc_drv = 3'h0, addr = 3'h0;
  logic [2:0] pc_ext = 3'h0;
  logic [7:0] pb_dat = 8'h00, pb_drv = 8'h00, fdb = 8'h00, mdata = 8'h00;
  logic       fdd = 1'b0, commit = 1'b0, sel = 1'b0, mdrive = 1'b1;
  logic [3:0] strb = 4'hF;
  wire logic  pa6_o, pa6_oe, pa7_o, pa7_oe, pa6_w, pa7_w;
  wire logic  commit_o, sel_o, pd_o;
  wire logic [7:0] pb_o, pb_oe, pb_w, pb_rd, fdo;
  wire logic [2:0] pc_o, pc_oe, pc_w, pc_rd;
  wire logic [1:0] pa_rd;
  wire logic [3:0] gs_o;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #10 clk_in = ~clk_in;

  assign pc_w = (pc_o & ~pc_oe) | (pc_ext & pc_oe);

  pam_fifo_master i_master (
    .clk_in(clk_in), .commit_in(commit), .pol_high_in(pol[5]),
    .select_in(sel), .drive_in(mdrive), .data_in(mdata),
    .pa6_in(pa6_o), .pa6_oe_n_in(pa6_oe), .pa7_in(pa7_o),
    .pa7_oe_n_in(pa7_oe), .pb_in(pb_o), .pb_oe_n_in(pb_oe),
    .pa6_out(pa6_w), .pa7_out(pa7_w), .pb_out(pb_w));

  pam_port_abc_mux i_dut (
    .clk_in(clk_in), .reset_n_in(reset_n),
    .interface_mode_config_in(mode), .fifo_pin_polarity_config_in(pol),
    .port_a_alt_config_in(pa_alt), .port_c_alt_config_in(pc_alt),
    .endpoint_fifo_config_in(ep_cfg), .flag_d_select_in(flag_sel),
    .fifo_empty_in(cond[0]), .fifo_full_in(cond[1]),
    .fifo_prog_level_in(cond[2]), .port_a_data_in(pa_dat),
    .port_a_drive_in(pa_drv), .port_b_data_in(pb_dat),
    .port_b_drive_in(pb_drv), .port_c_data_in(pc_dat),
    .port_c_drive_in(pc_drv), .fifo_data_bus_in(fdb),
    .fifo_data_drive_in(fdd), .waveform_if_addr_in(addr),
    .fifo_strobes_in(strb), .port_a_bit6_in(pa6_w),
    .port_a_bit6_out(pa6_o), .port_a_bit6_oe_n_out(pa6_oe),
    .port_a_bit7_in(pa7_w), .port_a_bit7_out(pa7_o),
    .port_a_bit7_oe_n_out(pa7_oe), .port_b_pin_in(pb_w),
    .port_b_pin_out(pb_o), .port_b_oe_n_out(pb_oe), .port_c_pin_in(pc_w),
    .port_c_pin_out(pc_o), .port_c_oe_n_out(pc_oe),
    .port_a_read_out(pa_rd), .port_b_read_out(pb_rd),
    .port_c_read_out(pc_rd), .fifo_data_bus_out(fdo),
    .packet_commit_out(commit_o), .slave_selected_out(sel_o),
    .gated_strobes_out(gs_o), .port_d_upper_sel_out(pd_o));

  task automatic check(input logic [7:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Counts commit pulses over a window; one assertion must give one pulse.
  task automatic count_commits(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      if (commit_o === 1'b1) c++;
    end
  endtask

  task automatic close_out();
    $display("checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic t_gpio();
    int c;
    @(posedge clk_in);
    {pa_drv, pa_dat, pb_drv, pb_dat} <= {2'h3, 2'h2, 8'hFF, 8'h5A};
    {pc_drv, pc_dat} <= {3'h7, 3'h6};
    step(3);
    check({4'h0, pa7_o, pa6_o, pa7_oe, pa6_oe}, 8'h08, "pa drive");
    check(pb_o & ~pb_oe, 8'h5A, "pb drive");
    check({2'h0, pc_oe, pc_o}, 8'h06, "pc drive");
    @(posedge clk_in);
    {pa_drv, pb_drv, pc_drv} <= 13'h0;
    {mdata, commit, sel, pc_ext} <= {8'hC3, 1'b1, 1'b1, 3'h5};
    count_commits(6, c);
    check(8'(c), 8'h00, "commit in port mode");
    check({pa7_oe, pa6_oe, pb_oe[0], pc_oe, pa_rd}, 8'hFD, "release");
    check(pb_rd, 8'hC3, "pb read");
    check({1'b0, pc_rd, gs_o}, 8'h5F, "pc read");
  endtask

  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_in);
      {mode, commit, sel, pa_drv, pb_drv} <= {2'(m), 2'h0, 2'h3, 8'hFF};
      {fdb, fdd} <= {8'h96, 1'b1};
      step(4);
      check(pb_o, (m >= 2) ? 8'h96 : 8'h5A, "pb function");
      check({6'h0, pa6_oe, pd_o}, {6'h0, m == 3, m >= 2}, "pa6, pd");
    end
    @(posedge clk_in);
    ep_cfg <= 8'h00;
    step(4);
    check({7'h0, pd_o}, 8'h00, "pd byte wide");
  endtask

  task automatic t_flag();
    logic [1:0] s;
    logic [2:0] cv;
    logic       e;
    for (int k = 0; k < 8; k++) begin
      s = 2'(k);
      cv = (k < 4) ? 3'h5 : 3'h2;
      e = (s == 2'h0) ? cv[0] : (s == 2'h1) ? cv[1] : (s == 2'h3) & cv[2];
      @(posedge clk_in);
      {flag_sel, cond} <= {s, cv};
      step(3);
      check({6'h0, pa7_oe, pa7_o}, {7'h0, e}, "flag d");
    end
  endtask

  task automatic t_select();
    int c;
    @(posedge clk_in);
    {pa_alt, fdd, fdb, sel, mdrive} <= {8'h80, 1'b1, 8'h3C, 2'h0};
    // Strobes and drive are gated by the registered select, one edge late.
    step(6);
    check({pa7_oe, sel_o, gs_o, 2'h0}, 8'h80, "deselected");
    check(pb_oe, 8'hFF, "pb gated");
    @(posedge clk_in);
    commit <= 1'b1;
    count_commits(6, c);
    check(8'(c), 8'h00, "commit deselected");
    @(posedge clk_in);
    {commit, sel} <= 2'b01;
    step(5);
    check({pa7_oe, sel_o, gs_o, 2'h0}, 8'hFC, "selected");
    check(pb_o & ~pb_oe, 8'h3C, "pb bus out");
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_in);
      pol <= {2'h0, p[0], 5'h0};
      step(5);
      @(posedge clk_in);
      commit <= 1'b1;
      count_commits(8, c);
      check(8'(c), 8'h01, "commit pulse");
      @(posedge clk_in);
      commit <= 1'b0;
      step(4);
    end
    @(posedge clk_in);
    {fdd, mdrive, mdata} <= {2'b01, 8'hA5};
    step(5);
    check(pb_oe, 8'hFF, "pb released");
    check(fdo, 8'hA5, "pb inbound");
  endtask

  task automatic t_addr();
    @(posedge clk_in);
    {mode, pc_alt, addr, pc_drv, pc_dat} <= {2'h0, 8'h05, 9'h1F8};
    step(4);
    check({2'h0, pc_oe, pc_o}, 8'h05, "pc mixed");
    @(posedge clk_in);
    pc_drv <= 3'h0;
    step(3);
    check({5'h0, pc_oe}, 8'h02, "pc address kept");
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    step(5);
    check({pa7_oe, pa6_oe, commit_o, sel_o, gs_o}, 8'hD0, "in reset");
    check({4'h0, pc_oe, pd_o}, 8'h0E, "pc, pd in reset");
    repeat (5) @(posedge clk_in);
    reset_n <= 1'b1;
    step(2);
    check({pa7_oe, pa6_oe, pb_oe[7:2]}, 8'hFF, "after reset");
    t_gpio();
    t_modes();
    t_flag();
    t_select();
    t_addr();
    close_out();
  end
endmodule

`default_nettype wire
